// file: common/etcu_map.vh
// Purpose: constants of the event timer capture unit
// Assumes: byte wide register port, 4-bit address
// Notes: definitions only
`ifndef ETCU_MAP_VH
`define ETCU_MAP_VH
// --------------------------------------------------
// Register offsets
// --------------------------------------------------
`define ETCU_A_CTRL_A 4'h0
`define ETCU_A_CTRL_B 4'h1
`define ETCU_A_EVCTL 4'h4
`define ETCU_A_INTCTL 4'h5
`define ETCU_A_FLAGS 4'h6
`define ETCU_A_STATUS 4'h7
`define ETCU_A_DBGCTL 4'h8
`define ETCU_A_TEMP 4'h9
`define ETCU_A_CNT_L 4'hA
`define ETCU_A_CNT_H 4'hB
`define ETCU_A_CCV_L 4'hC
`define ETCU_A_CCV_H 4'hD
// --------------------------------------------------
// Field positions
// --------------------------------------------------
`define ETCU_B_ENABLE 0
`define ETCU_B_CLOCK_PRESCALE_SELECT_LO 1
`define ETCU_B_CLOCK_PRESCALE_SELECT_HI 2
`define ETCU_B_MODE_LO 0
`define ETCU_B_MODE_HI 2
`define ETCU_B_IMMED 6
`define ETCU_B_SAMPLE_DONE_FLAG_EI 0
`define ETCU_B_EDGE 4
`define ETCU_B_FLAG 0
`define ETCU_B_RUN 0
`define ETCU_B_DEBUG_KEEP_RUNNING 0
// --------------------------------------------------
// Modes and prescale codes
// --------------------------------------------------
`define ETCU_M_PERIODIC 3'h0
`define ETCU_M_TIMEOUT 3'h1
`define ETCU_M_CAPTURE 3'h2
`define ETCU_M_FREQ 3'h3
`define ETCU_M_PULSE 3'h4
`define ETCU_M_FREQ_PW 3'h5
`define ETCU_M_SINGLE 3'h6
`define ETCU_M_PWM8 3'h7
`define ETCU_CS_DIV1 2'h0
`define ETCU_CS_DIV2 2'h1
`define ETCU_PRE_DIV4_END 2'h3
// --------------------------------------------------
// Reset values
// --------------------------------------------------
`define ETCU_R_BYTE 8'h00
`define ETCU_R_WORD 16'h0000
`define ETCU_R_MODE 3'h0
`define ETCU_R_CLOCK_PRESCALE_SELECT 2'h0
`define ETCU_R_PRE 2'h0
`define ETCU_R_PHASE 4'h1
`endif

// file: src/etcu_top.v
// Purpose: 16-bit event timer with capture and single shot
// Assumes: event input synchronous to clk, byte register port
// Notes: 16-bit registers use a shared byte temp
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "etcu_map.vh"

module etcu_top (
	input wire clk,
	input wire nrst,
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata_q,
	input wire dbg_halt,
	input wire ev_in,
	output reg ev_out_q,
	output reg irq_q,
	output reg wave_q
);

// --------------------------------------------------
// Reset release
// --------------------------------------------------
reg rst_meta_n_q;
reg rst_n_q;

always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		rst_meta_n_q <= 1'b0;
		rst_n_q <= 1'b0;
	end
	else
	begin
		rst_meta_n_q <= 1'b1;
		rst_n_q <= rst_meta_n_q;
	end
end

// --------------------------------------------------
// State
// --------------------------------------------------
localparam PH_WAIT = 4'h1;
localparam PH_RUN = 4'h2;
localparam PH_SAMPLE_DONE_FLAG = 4'h4;
localparam PH_DONE = 4'h8;

reg en_q;
reg [1:0] clock_prescale_select_q;
reg [2:0] mode_q;
reg immed_q;
reg sample_done_flag_ei_q;
reg edge_q;
reg inten_q;
reg flag_q;
reg debug_keep_running_q;
reg [7:0] temp_q;
reg [15:0] cnt_q;
reg [15:0] ccv_q;
reg [1:0] pre_q;
reg ev_q;
reg to_arm_q;
reg to_frz_q;
reg [3:0] ph_q;
reg ss_trig_q;
reg ss_hold_q;

// --------------------------------------------------
// Tick and edges
// --------------------------------------------------
wire halted = dbg_halt & ~debug_keep_running_q;
wire act = en_q & ~halted;
wire pre_hit = (clock_prescale_select_q == `ETCU_CS_DIV1) ||
	((clock_prescale_select_q == `ETCU_CS_DIV2) && pre_q[0]) ||
	(pre_q == `ETCU_PRE_DIV4_END);
wire tick = act & pre_hit;
wire ev_ok = act & sample_done_flag_ei_q;
wire rise = ev_ok & ev_in & ~ev_q;
wire fall = ev_ok & ~ev_in & ev_q;
wire sel = edge_q ? fall : rise;
wire at_top = (cnt_q == ccv_q);
wire [15:0] cnt_inc = cnt_q + 16'h0001;
wire rd_ccv_h = rd && (addr == `ETCU_A_CCV_H);
wire wr_clr = wr && (addr == `ETCU_A_FLAGS) && wdata[`ETCU_B_FLAG];
wire is_ss = (mode_q == `ETCU_M_SINGLE);
wire ss_start = is_ss & sel & ~ss_hold_q;

// --------------------------------------------------
// Mode engine
// --------------------------------------------------
reg [15:0] cnt_d;
reg cap_d;
reg set_d;
reg to_arm_d;
reg to_frz_d;
reg [3:0] ph_d;
reg ss_hold_d;
reg run_d;

always @*
begin
	cnt_d = cnt_q;
	cap_d = 1'b0;
	set_d = 1'b0;
	to_arm_d = to_arm_q;
	to_frz_d = to_frz_q;
	ph_d = ph_q;
	ss_hold_d = ss_hold_q;
	run_d = en_q;
	case (mode_q)
	`ETCU_M_TIMEOUT:
	begin
		run_d = en_q & ~to_frz_q;
		if (sel && (to_frz_q || !to_arm_q))
		begin
			cnt_d = 16'h0000;
			to_arm_d = 1'b1;
			to_frz_d = 1'b0;
		end
		else if (sel)
		begin
			to_frz_d = 1'b1;
			to_arm_d = 1'b0;
		end
		else if (tick && !to_frz_q)
		begin
			cnt_d = cnt_inc;
			set_d = to_arm_q && (cnt_inc == ccv_q);
		end
	end
	`ETCU_M_CAPTURE:
	begin
		if (tick)
			cnt_d = cnt_inc;
		if (sel)
		begin
			cap_d = 1'b1;
			set_d = 1'b1;
		end
	end
	`ETCU_M_FREQ:
	begin
		if (sel)
		begin
			cap_d = 1'b1;
			set_d = 1'b1;
			cnt_d = 16'h0000;
		end
		else if (tick)
			cnt_d = cnt_inc;
	end
	`ETCU_M_PULSE:
	begin
		// Edge bit swaps which edge restarts
		if (edge_q ? fall : rise)
			cnt_d = 16'h0000;
		else if (edge_q ? rise : fall)
		begin
			cap_d = 1'b1;
			set_d = 1'b1;
		end
		else if (tick)
			cnt_d = cnt_inc;
	end
	`ETCU_M_FREQ_PW:
	begin
		run_d = en_q & (ph_q[1] | ph_q[2]);
		case (ph_q)
		PH_WAIT:
			if (rise)
			begin
				cnt_d = 16'h0000;
				ph_d = PH_RUN;
			end
		PH_RUN:
		begin
			// Keep ticking on the capture edge so the period loses no count
			if (tick)
				cnt_d = cnt_inc;
			if (fall)
			begin
				cap_d = 1'b1;
				ph_d = PH_SAMPLE_DONE_FLAG;
			end
		end
		PH_SAMPLE_DONE_FLAG:
			if (rise)
			begin
				set_d = 1'b1;
				ph_d = PH_DONE;
			end
			else if (tick)
				cnt_d = cnt_inc;
		PH_DONE:
			if (rd_ccv_h || wr_clr)
				ph_d = PH_WAIT;
		default:
			ph_d = PH_WAIT;
		endcase
	end
	`ETCU_M_SINGLE:
	begin
		run_d = en_q & ~at_top;
		if (ss_trig_q)
			cnt_d = 16'h0000;
		else if (tick && !at_top)
		begin
			cnt_d = cnt_inc;
			if (cnt_inc == ccv_q)
			begin
				ss_hold_d = 1'b1;
				set_d = 1'b1;
			end
		end
		else if (tick && ss_hold_q)
			ss_hold_d = 1'b0;
	end
	default:
	begin
		// Periodic; PWM mode counts the same way here
		if (tick && at_top)
		begin
			cnt_d = 16'h0000;
			set_d = (mode_q == `ETCU_M_PERIODIC);
		end
		else if (tick)
			cnt_d = cnt_inc;
	end
	endcase
end

// --------------------------------------------------
// Registers and counter
// --------------------------------------------------
always @(posedge clk or negedge rst_n_q)
begin
	if (!rst_n_q)
	begin
		en_q <= 1'b0;
		clock_prescale_select_q <= `ETCU_R_CLOCK_PRESCALE_SELECT;
		mode_q <= `ETCU_R_MODE;
		immed_q <= 1'b0;
		sample_done_flag_ei_q <= 1'b0;
		edge_q <= 1'b0;
		inten_q <= 1'b0;
		flag_q <= 1'b0;
		debug_keep_running_q <= 1'b0;
		temp_q <= `ETCU_R_BYTE;
		cnt_q <= `ETCU_R_WORD;
		ccv_q <= `ETCU_R_WORD;
		pre_q <= `ETCU_R_PRE;
		ev_q <= 1'b0;
		to_arm_q <= 1'b0;
		to_frz_q <= 1'b0;
		ph_q <= `ETCU_R_PHASE;
		ss_trig_q <= 1'b0;
		ss_hold_q <= 1'b0;
		rdata_q <= `ETCU_R_BYTE;
		ev_out_q <= 1'b0;
		irq_q <= 1'b0;
		wave_q <= 1'b0;
	end
	else
	begin
		ev_q <= ev_in;
		pre_q <= (act && !pre_hit) ? pre_q + 2'h1 : `ETCU_R_PRE;
		// Two-stage start gives the documented event latency
		ss_trig_q <= ss_start;
		ss_hold_q <= ss_hold_d;
		to_arm_q <= to_arm_d;
		to_frz_q <= to_frz_d;
		ph_q <= ph_d;
		cnt_q <= cnt_d;
		if (cap_d)
			ccv_q <= cnt_q;
		// Set beats a clear in the same cycle
		if (set_d)
			flag_q <= 1'b1;
		else if (wr_clr || rd_ccv_h)
			flag_q <= 1'b0;
		ev_out_q <= set_d;
		irq_q <= (flag_q | set_d) & inten_q;
		wave_q <= is_ss & en_q & ((cnt_d != ccv_q) | (immed_q & ss_start));
		rdata_q <= `ETCU_R_BYTE;
		if (rd)
		begin
			case (addr)
			`ETCU_A_CTRL_A:
				rdata_q <= {5'h00, clock_prescale_select_q, en_q};
			`ETCU_A_CTRL_B:
				rdata_q <= {1'b0, immed_q, 3'h0, mode_q};
			`ETCU_A_EVCTL:
				rdata_q <= {3'h0, edge_q, 3'h0, sample_done_flag_ei_q};
			`ETCU_A_INTCTL:
				rdata_q <= {7'h00, inten_q};
			`ETCU_A_FLAGS:
				rdata_q <= {7'h00, flag_q};
			`ETCU_A_STATUS:
				rdata_q <= {7'h00, run_d};
			`ETCU_A_DBGCTL:
				rdata_q <= {7'h00, debug_keep_running_q};
			`ETCU_A_TEMP:
				rdata_q <= temp_q;
			`ETCU_A_CNT_L:
			begin
				rdata_q <= cnt_q[7:0];
				temp_q <= cnt_q[15:8];
			end
			`ETCU_A_CCV_L:
			begin
				rdata_q <= ccv_q[7:0];
				temp_q <= ccv_q[15:8];
			end
			`ETCU_A_CNT_H, `ETCU_A_CCV_H:
				rdata_q <= temp_q;
			default:
				rdata_q <= `ETCU_R_BYTE;
			endcase
		end
		if (wr)
		begin
			case (addr)
			`ETCU_A_CTRL_A:
			begin
				en_q <= wdata[`ETCU_B_ENABLE];
				clock_prescale_select_q <= wdata[`ETCU_B_CLOCK_PRESCALE_SELECT_HI:`ETCU_B_CLOCK_PRESCALE_SELECT_LO];
			end
			`ETCU_A_CTRL_B:
			begin
				mode_q <= wdata[`ETCU_B_MODE_HI:`ETCU_B_MODE_LO];
				immed_q <= wdata[`ETCU_B_IMMED];
				to_arm_q <= 1'b0;
				to_frz_q <= 1'b0;
				ph_q <= PH_WAIT;
				ss_hold_q <= 1'b0;
			end
			`ETCU_A_EVCTL:
			begin
				sample_done_flag_ei_q <= wdata[`ETCU_B_SAMPLE_DONE_FLAG_EI];
				edge_q <= wdata[`ETCU_B_EDGE];
			end
			`ETCU_A_INTCTL:
				inten_q <= wdata[`ETCU_B_FLAG];
			`ETCU_A_DBGCTL:
				debug_keep_running_q <= wdata[`ETCU_B_DEBUG_KEEP_RUNNING];
			`ETCU_A_TEMP, `ETCU_A_CNT_L, `ETCU_A_CCV_L:
				temp_q <= wdata;
			`ETCU_A_CNT_H:
				cnt_q <= {wdata, temp_q};
			`ETCU_A_CCV_H:
				ccv_q <= {wdata, temp_q};
			default:
				temp_q <= temp_q;
			endcase
		end
	end
end

endmodule // etcu_top

// file: sim/etcu_properties.sv
// Purpose: port checker for etcu_top
// Assumes: control writes seen on the byte port
// Notes: shadows only the control bits it needs
`timescale 1ns/1ps
`include "etcu_map.vh"
module etcu_props (
	input wire clk,
	input wire nrst,
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire [7:0] rdata_q,
	input wire dbg_halt,
	input wire ev_in,
	input wire ev_out_q,
	input wire irq_q,
	input wire wave_q
);
reg ie_q;
reg dbg_run_q;
reg [2:0] mode_q;
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
// ----
// Shadows, raw reset: no writes right after release
// ----
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		ie_q <= 1'b0;
		dbg_run_q <= 1'b0;
		mode_q <= `ETCU_R_MODE;
	end
	else if (wr)
	begin
		if (addr == `ETCU_A_INTCTL)
			ie_q <= wdata[0];
		if (addr == `ETCU_A_DBGCTL)
			dbg_run_q <= wdata[0];
		if (addr == `ETCU_A_CTRL_B)
			mode_q <= wdata[2:0];
	end
end
// ----
// Assertions
// ----
a_read_idle: assert property (!$past(rd) |-> rdata_q == 8'h00)
	else $error("read data outside answer cycle");
a_unmapped_zero: assert property (rd && (addr == 4'h2 || addr == 4'h3 || addr > 4'hD)
	|=> rdata_q == 8'h00) else $error("unmapped read not zero");
a_wave_mode: assert property (mode_q != `ETCU_M_SINGLE |=> !wave_q)
	else $error("wave out of single shot");
a_irq_enable: assert property (!ie_q |=> !irq_q) else $error("irq while disabled");
a_irq_hold: assert property (irq_q && !wr && !rd && !$past(wr) && !$past(rd) |=> irq_q)
	else $error("irq dropped by itself");
a_strobe_irq: assert property (ev_out_q && $past(ie_q) |-> irq_q)
	else $error("strobe without irq");
a_halt_quiet: assert property (dbg_halt && !dbg_run_q |=> !ev_out_q)
	else $error("strobe while halted");
a_capture_clear: assert property (rd && addr == `ETCU_A_CCV_H
	|-> (##1 ev_out_q) or (##2 (ev_out_q || !irq_q))) else $error("flag kept after read");
c_strobe: cover property (ev_out_q);
c_wave: cover property ($rose(wave_q));
c_irq: cover property (irq_q && ie_q);
endmodule // etcu_props

bind etcu_top etcu_props u_props (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata_q(rdata_q), .dbg_halt(dbg_halt), .ev_in(ev_in),
	.ev_out_q(ev_out_q), .irq_q(irq_q), .wave_q(wave_q));

// file: sim/etcu_ev_src.sv
// Purpose: event routing model feeding the timer
// Assumes: one fire request per pulse
// Notes: pulse length is HOLD clocks
`timescale 1ns/1ps
module etcu_ev_src #(
	parameter [3:0] HOLD = 4'h3
) (
	input wire clk,
	input wire fire,
	output wire ev
);
reg [3:0] left_q = 4'h0;
// ----
// Pulse stretch, keeps edges apart
// ----
always @(posedge clk)
begin
	if (fire)
		left_q <= HOLD;
	else if (left_q != 4'h0)
		left_q <= left_q - 4'h1;
end
assign ev = (left_q != 4'h0);
endmodule // etcu_ev_src

// file: sim/test_etcu_top.sv
// Purpose: self-checking bench for etcu_top
// Assumes: 50 MHz clock, byte register port
// Notes: wrap test makes the run about 70k clocks
`timescale 1ns/1ps
`include "etcu_map.vh"
module test_etcu_top;
reg clk = 1'b0;
reg nrst = 1'b0;
reg [3:0] addr = 4'h0;
reg [7:0] wdata = 8'h00;
reg wr = 1'b0;
reg rd = 1'b0;
reg dbg_halt = 1'b0;
reg fire = 1'b0;
wire ev;
wire [7:0] rdata_q;
wire ev_out_q;
wire irq_q;
wire wave_q;
integer fails = 0;
integer check_count = 0;
integer n;
integer m;
reg [15:0] a;
reg [15:0] b;
reg [15:0] c;
etcu_top DUT (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata_q(rdata_q), .dbg_halt(dbg_halt), .ev_in(ev), .ev_out_q(ev_out_q),
	.irq_q(irq_q), .wave_q(wave_q));
etcu_ev_src u_src (.clk(clk), .fire(fire), .ev(ev));
initial forever #10 clk = ~clk;
// ----
// Tasks
// ----
task chk(input string what, input [15:0] exp, input [15:0] got);
begin
	check_count = check_count + 1;
	if (got !== exp)
	begin
		$display("unexpected %0s exp %h got %h", what, exp, got);
		fails = fails + 1;
	end
end
endtask
task wb(input [3:0] ad, input [7:0] d);
begin
	@(posedge clk);
	addr <= ad;
	wdata <= d;
	wr <= 1'b1;
	@(posedge clk);
	wr <= 1'b0;
end
endtask
task rb(input [3:0] ad, output [15:0] d);
begin
	@(posedge clk);
	addr <= ad;
	rd <= 1'b1;
	@(posedge clk);
	rd <= 1'b0;
	#1;
	d = {8'h00, rdata_q};
end
endtask
task w16(input [3:0] ad, input [15:0] v);
begin
	wb(ad, v[7:0]);
	wb(ad + 4'h1, v[15:8]);
end
endtask
task r16(input [3:0] ad, output [15:0] v);
reg [15:0] lo;
reg [15:0] hi;
begin
	rb(ad, lo);
	rb(ad + 4'h1, hi);
	v = {hi[7:0], lo[7:0]};
end
endtask
task ev_go;
begin
	@(posedge clk);
	fire <= 1'b1;
	@(posedge clk);
	fire <= 1'b0;
end
endtask
task wait_ev(output integer k);
begin
	k = 0;
	do
	begin
		@(posedge clk);
		#1;
		k = k + 1;
	end
	while (ev_out_q !== 1'b1 && k < 70000);
end
endtask
task summarize;
begin
	$display("checks %0d mismatches %0d", check_count, fails);
	if (fails == 0 && check_count > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
end
endtask
initial
begin
	repeat (90000) @(posedge clk);
	fails = fails + 1;
	summarize;
end
// ----
// Tests
// ----
initial
begin
	repeat (5) @(posedge clk);
	nrst <= 1'b1;
	repeat (3) @(posedge clk);
	rb(`ETCU_A_CTRL_B, a);
	chk("mode", 16'h0000, a);
	rb(4'h2, a);
	chk("unmapped", 16'h0000, a);
	r16(`ETCU_A_CCV_L, a);
	chk("compare", 16'h0000, a);
	$display("reset test done");
	wb(`ETCU_A_INTCTL, 8'h01);
	w16(`ETCU_A_CCV_L, 16'h0004);
	for (m = 0; m < 4; m = m + 1)
	begin
		wb(`ETCU_A_CTRL_A, {5'h00, m[1:0], 1'b1});
		wait_ev(n);
		wait_ev(n);
		chk("period", (m == 0) ? 16'h0005 : (m == 1) ? 16'h000A : 16'h0014, n[15:0]);
		chk("irq", 16'h0001, {15'h0000, irq_q});
	end
	wb(`ETCU_A_CTRL_A, 8'h01);
	w16(`ETCU_A_CCV_L, 16'h00C8);
	wait_ev(n);
	repeat (50) @(posedge clk);
	w16(`ETCU_A_CCV_L, 16'h0010);
	wait_ev(n);
	chk("wrap", 16'h0001, {15'h0000, (n > 60000) && (n < 70000)});
	$display("periodic test done");
	@(posedge clk);
	dbg_halt <= 1'b1;
	rb(`ETCU_A_CNT_L, a);
	repeat (8) @(posedge clk);
	rb(`ETCU_A_CNT_L, b);
	chk("halt", a, b);
	wb(`ETCU_A_DBGCTL, 8'h01);
	rb(`ETCU_A_CNT_L, c);
	chk("debug_keep_running", 16'h0000, {15'h0000, c == b});
	wb(`ETCU_A_DBGCTL, 8'h00);
	dbg_halt <= 1'b0;
	$display("debug test done");
	for (m = 2; m < 4; m = m + 1)
	begin
		wb(`ETCU_A_CTRL_B, {5'h00, m[2:0]});
		w16(`ETCU_A_CNT_L, 16'h0000);
		wb(`ETCU_A_EVCTL, {3'h0, m[0], 4'h1});
		ev_go;
		repeat (6) @(posedge clk);
		r16(`ETCU_A_CCV_L, a);
		repeat (26) @(posedge clk);
		ev_go;
		repeat (6) @(posedge clk);
		r16(`ETCU_A_CCV_L, b);
		repeat (36) @(posedge clk);
		ev_go;
		repeat (6) @(posedge clk);
		r16(`ETCU_A_CCV_L, c);
		chk("capture", (m == 2) ? 16'h0030 : 16'h000A, c - b);
		@(posedge clk);
		#1;
		chk("flag", 16'h0000, {15'h0000, irq_q});
	end
	$display("capture test done");
	wb(`ETCU_A_CTRL_A, 8'h00);
	wb(`ETCU_A_CTRL_B, 8'h06);
	w16(`ETCU_A_CCV_L, 16'h000A);
	w16(`ETCU_A_CNT_L, 16'h0000);
	wb(`ETCU_A_EVCTL, 8'h01);
	wb(`ETCU_A_CTRL_A, 8'h01);
	repeat (3) @(posedge clk);
	#1;
	chk("start", 16'h0001, {15'h0000, wave_q});
	for (m = 0; m < 2; m = m + 1)
	begin
		repeat (20) @(posedge clk);
		wb(`ETCU_A_CTRL_B, {1'b0, m[0], 6'h06});
		w16(`ETCU_A_CNT_L, 16'h000A);
		#1;
		chk("idle", 16'h0000, {15'h0000, wave_q});
		ev_go;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n = n + 1;
		end
		while (wave_q !== 1'b1 && n < 20);
		chk("rise", 16'h0002 - m[15:0], n[15:0]);
		rb(`ETCU_A_STATUS, a);
		chk("run", 16'h0001, a);
		repeat (20) @(posedge clk);
		rb(`ETCU_A_STATUS, a);
		chk("stop", 16'h0000, a);
	end
	$display("single shot test done");
	wb(`ETCU_A_FLAGS, 8'h01);
	wb(`ETCU_A_CTRL_B, 8'h04);
	ev_go;
	repeat (6) @(posedge clk);
	rb(`ETCU_A_FLAGS, a);
	chk("width flag", 16'h0001, a);
	r16(`ETCU_A_CCV_L, a);
	chk("width", 16'h0002, a);
	wb(`ETCU_A_CTRL_B, 8'h05);
	ev_go;
	repeat (10) @(posedge clk);
	ev_go;
	repeat (4) @(posedge clk);
	r16(`ETCU_A_CNT_L, a);
	chk("period count", 16'h000B, a);
	chk("period irq", 16'h0001, {15'h0000, irq_q});
	r16(`ETCU_A_CCV_L, b);
	chk("duty", 16'h0002, b);
	@(posedge clk);
	#1;
	chk("rearm irq", 16'h0000, {15'h0000, irq_q});
	$display("pulse test done");
	w16(`ETCU_A_CCV_L, 16'h0008);
	wb(`ETCU_A_CTRL_B, 8'h01);
	ev_go;
	wait_ev(n);
	chk("timeout", 16'h0009, n[15:0]);
	ev_go;
	repeat (4) @(posedge clk);
	rb(`ETCU_A_STATUS, a);
	chk("frozen run", 16'h0000, a);
	r16(`ETCU_A_CNT_L, b);
	wb(`ETCU_A_STATUS, 8'h01);
	r16(`ETCU_A_CNT_L, c);
	chk("frozen count", b, c);
	rb(`ETCU_A_STATUS, a);
	chk("run write", 16'h0000, a);
	ev_go;
	repeat (4) @(posedge clk);
	rb(`ETCU_A_STATUS, a);
	chk("restart", 16'h0001, a);
	$display("timeout test done");
	summarize;
end
endmodule // test_etcu_top
